//--- logic/mpss_consts.svh
// constants for the multiphase startup sequencer
`ifndef MPSS_CONSTS_SVH
`define MPSS_CONSTS_SVH

// command codes of the two startup registers
`define MPSS_CMD_DELAY 8'hD4
`define MPSS_CMD_SLEW 8'hD5
// field position of the 3-bit codes
`define MPSS_CODE_MSB 2
// reset values of the codes
`define MPSS_DELAY_RST 3'h3
`define MPSS_SLEW_RST 3'h2
// reference clock rate
`define MPSS_CLK_MHZ 250
// delay timer step of 0.5 ms
`define MPSS_DLY_STEP_NS 500000
`define MPSS_DLY_STEP_CYC (`MPSS_DLY_STEP_NS * `MPSS_CLK_MHZ / 1000)
// time of one 6.25 mV step at the slowest slew of 0.1 V/ms
`define MPSS_SLEW_BASE_NS 62500
`define MPSS_SLEW_BASE_CYC (`MPSS_SLEW_BASE_NS * `MPSS_CLK_MHZ / 1000)
// power-good masking time
`define MPSS_PG_MASK_NS 250000
`define MPSS_PG_MASK_CYC (`MPSS_PG_MASK_NS * `MPSS_CLK_MHZ / 1000)
// master clock divider (resistor-set rate, 1 MHz default)
`define MPSS_MCLK_DIV 250
// master clock ticks spent on phase detection
`define MPSS_DETECT_TICKS 3'h6
// boot level 1.05 V in 6.25 mV units
`define MPSS_BOOT_CODE 8'hA8
// latchoff delay is the delay period shifted left by this
`define MPSS_LATCH_SHIFT 2

`endif

//--- logic/mpss_pkg.sv
// types of the multiphase startup sequencer
`default_nettype none
package mpss_pkg;

    // sequencer states
    typedef enum logic [3:0] {
        MPSS_IDLE = 4'b0000,
        MPSS_INIT_DELAY = 4'b0001,
        MPSS_DETECT = 4'b0010,
        MPSS_BOOT_RAMP = 4'b0011,
        MPSS_BOOT_HOLD = 4'b0100,
        MPSS_FINAL_RAMP = 4'b0101,
        MPSS_PG_MASK = 4'b0110,
        MPSS_GOOD_BLANK = 4'b0111,
        MPSS_RUN = 4'b1000,
        MPSS_LATCH_WAIT = 4'b1001,
        MPSS_LATCHED = 4'b1010
    } mpss_state_t;

    // whole state of the sequencer
    typedef struct packed {
        mpss_state_t state;
        logic [2:0] delay_code;
        logic [2:0] slew_code;
        logic [7:0] rdata;
        logic [15:0] mdiv;
        logic [2:0] ticks;
        logic [19:0] tmr;
        logic [4:0] units;
        logic [19:0] slew_cnt;
        logic [7:0] ref_code;
        logic [7:0] target;
        logic [2:0] tied;
        logic [1:0] slot;
        logic [3:0] drive;
        logic good;
    } mpss_st_t;

endpackage : mpss_pkg
`default_nettype wire

//--- logic/mpss_sequencer.sv
// startup sequencer of a multi-phase buck controller
`timescale 1ns/100ps
`default_nettype none
`include "mpss_consts.svh"

// Overview of operation
// - enable and lockout ok start initial delay
// - delay code selects 0.5 to 4 ms
// - command D4 bits 2:0 hold delay code
// - six master ticks of detection, no switching
// - ramp reference in 6.25 mV steps to boot
// - boot hold lasts one delay period
// - sample voltage select code, ramp up or down
// - mask time then one delay of good blanking
// - command D5 bits 2:0 pace both ramps
// - slew code 0.1 to 1.5 V/ms linear
// - latchoff delay is four delay periods
// - sink on phases 2-4, high means unused
// - phase 1 held low during detection
// - unused phases high impedance, others drive
// - per phase rate is master over active count if unused phases are the top ones
// - phases independent, overlap allowed
// - latchoff timing starts only after blanking
// - enable low or power cycle clears latchoff
module mpss_sequencer #(
    parameter int unsigned DLY_STEP_CYC = `MPSS_DLY_STEP_CYC,
    parameter int unsigned SLEW_BASE_CYC = `MPSS_SLEW_BASE_CYC,
    parameter int unsigned PG_MASK_CYC = `MPSS_PG_MASK_CYC,
    parameter int unsigned MCLK_DIV = `MPSS_MCLK_DIV
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic EN,
    input wire logic SUPPLY_LOCKOUT_OK,
    input wire logic CMD_WR,
    input wire logic [7:0] CMD_CODE,
    input wire logic [7:0] CMD_WDATA,
    output logic [7:0] CMD_RDATA,
    input wire logic [7:0] VOLTAGE_SELECT_CODE,
    input wire logic OVERCURRENT,
    input wire logic VOUT_IN_WINDOW,
    input wire logic [3:0] PHASE_END,
    input wire logic [3:1] PHASE_DRIVE_I,
    output logic [3:0] PHASE_DRIVE_O,
    output logic [3:0] PHASE_DRIVE_OE,
    output logic [3:1] PHASE_SINK_EN,
    output logic [7:0] REF_CODE,
    output logic OUTPUT_GOOD_FLAG,
    output logic LATCHED_OFF,
    output logic [2:0] ACTIVE_PHASES
);

    mpss_pkg::mpss_st_t s;
    mpss_pkg::mpss_st_t next_s;
    logic run_ok;
    logic mtick;
    logic switching;
    logic tmr_wrap;
    logic dly_done;
    logic slew_step;
    logic [5:0] dly_limit;
    logic [2:0] act_cnt;

    // cycles per 6.25 mV step for a slew code
    function automatic logic [19:0] slew_cycles(input logic [2:0] code);
        int unsigned q;
        q = SLEW_BASE_CYC / (32'd1 + 32'd2 * {29'd0, code});
        if (q == 0) begin
            q = 1;
        end
        return q[19:0];
    endfunction : slew_cycles

    // number of active phases from the tied-high pins
    function automatic logic [2:0] phase_count(input logic [2:0] tied);
        return 3'h4 - {2'b00, tied[0]} - {2'b00, tied[1]} - {2'b00, tied[2]};
    endfunction : phase_count

    // shared timing terms
    always_comb begin
        run_ok = EN && SUPPLY_LOCKOUT_OK;
        mtick = (s.mdiv == 16'(MCLK_DIV - 1));
        switching = (s.state >= mpss_pkg::MPSS_BOOT_RAMP) && (s.state != mpss_pkg::MPSS_LATCHED);
        tmr_wrap = (s.tmr == 20'(DLY_STEP_CYC - 1));
        // delay periods in 0.5 ms units; latchoff takes four of them
        dly_limit = 6'({3'b000, s.delay_code} + 6'h01);
        if (s.state == mpss_pkg::MPSS_LATCH_WAIT) begin
            dly_limit = dly_limit << `MPSS_LATCH_SHIFT;
        end
        dly_done = tmr_wrap && ({1'b0, s.units} == dly_limit - 6'h01);
        slew_step = (s.slew_cnt == slew_cycles(s.slew_code) - 20'h00001);
        act_cnt = phase_count(s.tied);
    end

    // next-state logic
    always_comb begin
        next_s = s;
        // free-running master clock divider
        next_s.mdiv = mtick ? 16'h0000 : s.mdiv + 16'h0001;
        next_s.tmr = tmr_wrap ? 20'h00000 : s.tmr + 20'h00001;
        next_s.units = s.units + {4'h0, tmr_wrap};
        next_s.slew_cnt = slew_step ? 20'h00000 : s.slew_cnt + 20'h00001;

        // command writes and registered read-back
        if (CMD_WR && CMD_CODE == `MPSS_CMD_DELAY) begin
            next_s.delay_code = CMD_WDATA[`MPSS_CODE_MSB:0];
        end else if (CMD_WR && CMD_CODE == `MPSS_CMD_SLEW) begin
            next_s.slew_code = CMD_WDATA[`MPSS_CODE_MSB:0];
        end
        if (CMD_CODE == `MPSS_CMD_DELAY) begin
            next_s.rdata = {5'h00, s.delay_code};
        end else if (CMD_CODE == `MPSS_CMD_SLEW) begin
            next_s.rdata = {5'h00, s.slew_code};
        end else begin
            next_s.rdata = 8'h00;
        end

        // startup sequence
        case (s.state)
            mpss_pkg::MPSS_IDLE: begin
                next_s.state = mpss_pkg::MPSS_INIT_DELAY;
            end
            mpss_pkg::MPSS_INIT_DELAY: begin
                if (dly_done) begin
                    next_s.state = mpss_pkg::MPSS_DETECT;
                end
            end
            mpss_pkg::MPSS_DETECT: begin
                next_s.ticks = s.ticks + {2'b00, mtick};
                // capture comparator levels on the last detection tick
                if (mtick && s.ticks == `MPSS_DETECT_TICKS - 3'h1) begin
                    next_s.tied = PHASE_DRIVE_I;
                    next_s.ref_code = 8'h00;
                    next_s.state = mpss_pkg::MPSS_BOOT_RAMP;
                end
            end
            mpss_pkg::MPSS_BOOT_RAMP: begin
                if (s.ref_code == `MPSS_BOOT_CODE) begin
                    next_s.state = mpss_pkg::MPSS_BOOT_HOLD;
                end else if (slew_step) begin
                    next_s.ref_code = s.ref_code + 8'h01;
                end
            end
            mpss_pkg::MPSS_BOOT_HOLD: begin
                if (dly_done) begin
                    next_s.target = VOLTAGE_SELECT_CODE;
                    next_s.state = mpss_pkg::MPSS_FINAL_RAMP;
                end
            end
            mpss_pkg::MPSS_FINAL_RAMP: begin
                if (s.ref_code == s.target) begin
                    next_s.state = mpss_pkg::MPSS_PG_MASK;
                end else if (slew_step && s.ref_code < s.target) begin
                    next_s.ref_code = s.ref_code + 8'h01;
                end else if (slew_step) begin
                    next_s.ref_code = s.ref_code - 8'h01;
                end
            end
            mpss_pkg::MPSS_PG_MASK: begin
                next_s.tmr = s.tmr + 20'h00001;
                if (s.tmr == 20'(PG_MASK_CYC - 1)) begin
                    next_s.state = mpss_pkg::MPSS_GOOD_BLANK;
                end
            end
            mpss_pkg::MPSS_GOOD_BLANK: begin
                if (dly_done) begin
                    next_s.state = mpss_pkg::MPSS_RUN;
                end
            end
            mpss_pkg::MPSS_RUN: begin
                // overcurrent is only timed once blanking is over
                if (OVERCURRENT) begin
                    next_s.state = mpss_pkg::MPSS_LATCH_WAIT;
                end
            end
            mpss_pkg::MPSS_LATCH_WAIT: begin
                if (!OVERCURRENT) begin
                    next_s.state = mpss_pkg::MPSS_RUN;
                end else if (dly_done) begin
                    next_s.state = mpss_pkg::MPSS_LATCHED;
                end
            end
            mpss_pkg::MPSS_LATCHED: begin
                next_s.state = mpss_pkg::MPSS_LATCHED;
            end
            default: begin
                next_s.state = mpss_pkg::MPSS_IDLE;
            end
        endcase

        // every interval starts with cleared timers
        if (next_s.state != s.state) begin
            next_s.tmr = 20'h00000;
            next_s.units = 5'h00;
            next_s.slew_cnt = 20'h00000;
        end

        // independent phase drives, rotating set slot
        for (int i = 0; i < 4; i++) begin
            if (PHASE_END[i]) begin
                next_s.drive[i] = 1'b0;
            end
        end
        if (switching && mtick) begin
            next_s.drive[s.slot] = 1'b1;
            next_s.slot = (s.slot == 2'(act_cnt - 3'h1)) ? 2'b00 : s.slot + 2'b01;
        end
        if (next_s.state < mpss_pkg::MPSS_BOOT_RAMP || next_s.state == mpss_pkg::MPSS_LATCHED) begin
            next_s.drive = 4'h0;
            next_s.slot = 2'b00;
        end
        next_s.drive = next_s.drive & {~next_s.tied, 1'b1};

        next_s.good = (next_s.state == mpss_pkg::MPSS_RUN || next_s.state == mpss_pkg::MPSS_LATCH_WAIT)
            && VOUT_IN_WINDOW;

        // loss of enable or supply abandons the sequence and clears latchoff
        if (!run_ok) begin
            next_s.state = mpss_pkg::MPSS_IDLE;
            next_s.drive = 4'h0;
            next_s.slot = 2'b00;
            next_s.ticks = 3'h0;
            next_s.tied = 3'h0;
            next_s.ref_code = 8'h00;
            next_s.good = 1'b0;
            next_s.tmr = 20'h00000;
            next_s.units = 5'h00;
        end

        if (RST) begin
            next_s = '0;
            next_s.state = mpss_pkg::MPSS_IDLE;
            next_s.delay_code = `MPSS_DELAY_RST;
            next_s.slew_code = `MPSS_SLEW_RST;
        end
    end

    // state register
    always_ff @(posedge REF_CLK) begin
        s <= next_s;
    end

    // outputs
    assign CMD_RDATA = s.rdata;
    assign PHASE_DRIVE_O = s.drive;
    assign PHASE_DRIVE_OE = {{3{switching}} & ~s.tied, 1'b1};
    assign PHASE_SINK_EN = {3{EN && s.state <= mpss_pkg::MPSS_DETECT}};
    assign REF_CODE = s.ref_code;
    assign OUTPUT_GOOD_FLAG = s.good;
    assign LATCHED_OFF = (s.state == mpss_pkg::MPSS_LATCHED);
    assign ACTIVE_PHASES = act_cnt;

    // cycles spent in the current state, for the checks below
    int unsigned h_cnt;
    always_ff @(posedge REF_CLK) begin
        if (RST || next_s.state != s.state) begin
            h_cnt <= 0;
        end else begin
            h_cnt <= h_cnt + 1;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    property p_init_len;
        (s.state == mpss_pkg::MPSS_INIT_DELAY && next_s.state == mpss_pkg::MPSS_DETECT)
            |-> h_cnt == (s.delay_code + 1) * DLY_STEP_CYC - 1;
    endproperty
    a_init_len: assert property (p_init_len) else $error("initial delay length wrong");

    property p_hold_len;
        (s.state == mpss_pkg::MPSS_BOOT_HOLD && next_s.state == mpss_pkg::MPSS_FINAL_RAMP)
            |-> h_cnt == (s.delay_code + 1) * DLY_STEP_CYC - 1;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("boot hold length wrong");

    property p_latch_len;
        (s.state == mpss_pkg::MPSS_LATCH_WAIT && next_s.state == mpss_pkg::MPSS_LATCHED)
            |-> h_cnt == 4 * (s.delay_code + 1) * DLY_STEP_CYC - 1;
    endproperty
    a_latch_len: assert property (p_latch_len) else $error("latchoff delay length wrong");

    property p_detect_quiet;
        (s.state == mpss_pkg::MPSS_DETECT) |-> (PHASE_DRIVE_O == 4'h0 && PHASE_DRIVE_OE[0]);
    endproperty
    a_detect_quiet: assert property (p_detect_quiet) else $error("phase switched during detection");

    property p_ramp_step;
        (s.state == mpss_pkg::MPSS_BOOT_RAMP && run_ok) |=> (s.ref_code - $past(s.ref_code)) <= 8'h01;
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("boot ramp step too large");

    property p_sample_code;
        $rose(s.state == mpss_pkg::MPSS_FINAL_RAMP) |-> s.target == $past(VOLTAGE_SELECT_CODE);
    endproperty
    a_sample_code: assert property (p_sample_code) else $error("target code not sampled");

    property p_drop_idle;
        !(EN && SUPPLY_LOCKOUT_OK) |=> (s.state == mpss_pkg::MPSS_IDLE && PHASE_DRIVE_O == 4'h0);
    endproperty
    a_drop_idle: assert property (p_drop_idle) else $error("no return to idle");

    property p_tied_hiz;
        ((PHASE_DRIVE_OE[3:1] | PHASE_DRIVE_O[3:1]) & s.tied) == 3'h0;
    endproperty
    a_tied_hiz: assert property (p_tied_hiz) else $error("tied phase is driven");

    property p_oc_after_blank;
        $rose(s.state == mpss_pkg::MPSS_LATCH_WAIT) |-> $past(s.state) == mpss_pkg::MPSS_RUN;
    endproperty
    a_oc_after_blank: assert property (p_oc_after_blank) else $error("latchoff timed too early");

    c_run: cover property (s.state == mpss_pkg::MPSS_RUN);
    c_latched: cover property (s.state == mpss_pkg::MPSS_LATCHED);
    c_ramp_down: cover property (s.state == mpss_pkg::MPSS_FINAL_RAMP && s.target < s.ref_code);
    c_overlap: cover property (PHASE_DRIVE_O[0] && PHASE_DRIVE_O[1]);

endmodule : mpss_sequencer
`default_nettype wire

//--- testbench/mpss_far_end.sv
// far side model: board phase ties and gate-driver duty end
`timescale 1ns/100ps
`default_nettype none
module mpss_far_end (
    input wire logic clk,
    input wire logic [3:1] tie,
    input wire logic [3:0] drv_o,
    input wire logic [3:0] drv_oe,
    output logic [3:1] pin_lvl,
    output logic [3:0] duty_end
);
    logic [3:0] seen = 4'h0;
    // tied pins sit above threshold, others follow drive or the sink
    always_comb begin
        for (int i = 1; i < 4; i++) begin
            pin_lvl[i] = tie[i] | (drv_oe[i] & drv_o[i]);
        end
    end
    // duty ends one cycle after the driver saw its phase rise
    always_ff @(posedge clk) begin
        seen <= drv_o & drv_oe;
    end
    assign duty_end = seen & drv_o;
endmodule : mpss_far_end
`default_nettype wire

//--- testbench/mpss_sequencer_tb_top.sv
// self-checking bench of the startup sequencer
`timescale 1ns/100ps
`default_nettype none
module mpss_sequencer_tb_top;
    localparam int DLY = 20;
    localparam int SLEW = 16;
    localparam int MASK = 10;
    localparam int DIV = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic lock_ok = 1'b0;
    logic cmd_wr = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] vsel = 8'h00;
    logic ocur = 1'b0;
    logic win = 1'b1;
    logic [3:1] tie = 3'h0;
    logic [3:1] pin_lvl;
    logic [3:0] duty_end;
    logic [7:0] v;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    // code, write data, expected read-back
    logic [7:0] tab [10][3] = '{'{8'hD4, 8'hF8, 8'h00}, '{8'hD4, 8'h01, 8'h01}, '{8'hD4, 8'h2D, 8'h05},
        '{8'hD4, 8'h16, 8'h06}, '{8'hD5, 8'hFE, 8'h06}, '{8'hD5, 8'h03, 8'h03}, '{8'hD5, 8'hE5, 8'h05},
        '{8'hD5, 8'h0C, 8'h04}, '{8'hD6, 8'h12, 8'h00}, '{8'h00, 8'hFF, 8'h00}};
    logic [7:0] CMD_RDATA, REF_CODE;
    logic [3:0] PHASE_DRIVE_O, PHASE_DRIVE_OE;
    logic [3:1] PHASE_SINK_EN;
    logic OUTPUT_GOOD_FLAG, LATCHED_OFF;
    logic [2:0] ACTIVE_PHASES;

    mpss_sequencer #(.DLY_STEP_CYC(DLY), .SLEW_BASE_CYC(SLEW), .PG_MASK_CYC(MASK), .MCLK_DIV(DIV)) dut (
        .REF_CLK(ref_clk), .RST(rst), .EN(en), .SUPPLY_LOCKOUT_OK(lock_ok), .CMD_WR(cmd_wr),
        .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .CMD_RDATA(CMD_RDATA), .VOLTAGE_SELECT_CODE(vsel),
        .OVERCURRENT(ocur), .VOUT_IN_WINDOW(win), .PHASE_END(duty_end), .PHASE_DRIVE_I(pin_lvl),
        .PHASE_DRIVE_O(PHASE_DRIVE_O), .PHASE_DRIVE_OE(PHASE_DRIVE_OE), .PHASE_SINK_EN(PHASE_SINK_EN),
        .REF_CODE(REF_CODE), .OUTPUT_GOOD_FLAG(OUTPUT_GOOD_FLAG), .LATCHED_OFF(LATCHED_OFF),
        .ACTIVE_PHASES(ACTIVE_PHASES));
    mpss_far_end far (.clk(ref_clk), .tie(tie), .drv_o(PHASE_DRIVE_O), .drv_oe(PHASE_DRIVE_OE),
        .pin_lvl(pin_lvl), .duty_end(duty_end));

    // clock of 4 ns
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run;
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        @(posedge ref_clk);
        cmd_wr <= 1'b1;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge ref_clk);
        cmd_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] c, output logic [7:0] d);
        @(posedge ref_clk);
        cmd_code <= c;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = CMD_RDATA;
    endtask : rd

    // one startup; stop cuts lockout in the boot ramp
    task automatic start_up(input logic [2:0] dl, input logic [2:0] sl, input logic [3:1] ti,
        input logic [7:0] voltage_select_code, input logic oc, input logic stop);
        int lim, n, g, st, act, r;
        logic [7:0] pv;
        logic p0;
        lim = (dl + 1) * DLY;
        act = 4 - $countones(ti);
        wr(8'hD4, {5'h00, dl});
        wr(8'hD5, {5'h00, sl});
        @(posedge ref_clk);
        tie <= ti;
        vsel <= voltage_select_code;
        ocur <= oc;
        en <= 1'b1;
        lock_ok <= 1'b1;
        for (n = 0; n < lim + 5 * DIV; n++) begin
            @(negedge ref_clk);
            chk("ref_idle", 20'h0, {12'h0, REF_CODE});
            chk("blank_drv", 20'h0, {16'h0, PHASE_DRIVE_O});
            if (n < lim) chk("sink", 20'h7, {17'h0, PHASE_SINK_EN});
        end
        g = 0;
        st = 0;
        pv = 8'h00;
        while (REF_CODE !== 8'hA8 && g < 300) begin
            @(negedge ref_clk);
            g++;
            if (REF_CODE !== pv) begin
                chk("boot_step", {12'h0, pv + 8'h01}, {12'h0, REF_CODE});
                if (st > 0) chk("slew_gap", 20'(SLEW / (1 + 2 * sl)), 20'(g));
                chk("drv_oe", {16'h0, ~ti, 1'b1}, {16'h0, PHASE_DRIVE_OE});
                chk("sink_off", 20'h0, {17'h0, PHASE_SINK_EN});
                chk("act", 20'(act), {17'h0, ACTIVE_PHASES});
                pv = REF_CODE;
                g = 0;
                st++;
                if (stop && st == 4) begin
                    @(posedge ref_clk);
                    lock_ok <= 1'b0;
                    repeat (3) @(negedge ref_clk);
                    chk("abort_drv", 20'h0, {16'h0, PHASE_DRIVE_O});
                    @(posedge ref_clk);
                    en <= 1'b0;
                    return;
                end
            end
        end
        for (n = 0; REF_CODE === 8'hA8 && n < 2000; n++) @(negedge ref_clk);
        chk("hold", 20'h1, {19'h0, n >= lim && n <= lim + SLEW + 4});
        pv = REF_CODE;
        chk("first_fin", {12'h0, voltage_select_code > 8'hA8 ? 8'hA9 : 8'hA7}, {12'h0, pv});
        for (g = 0; REF_CODE !== voltage_select_code && g < 300; g++) begin
            @(negedge ref_clk);
            if (REF_CODE !== pv) begin
                chk("fin_step", {12'h0, voltage_select_code > pv ? pv + 8'h01 : pv - 8'h01}, {12'h0, REF_CODE});
                pv = REF_CODE;
                g = 0;
            end
        end
        for (n = 0; OUTPUT_GOOD_FLAG !== 1'b1 && n < 3000; n++) @(negedge ref_clk);
        chk("blank", 20'h1, {19'h0, n >= MASK + lim && n <= MASK + lim + SLEW + 4});
        chk("early_latch", 20'h0, {19'h0, LATCHED_OFF});
        r = 0;
        p0 = PHASE_DRIVE_O[0];
        for (n = 0; n < 128; n++) begin
            @(negedge ref_clk);
            if (PHASE_DRIVE_O[0] === 1'b1 && p0 === 1'b0) r++;
            p0 = PHASE_DRIVE_O[0];
        end
        g = 128 / (DIV * act);
        chk("rate", 20'h1, {19'h0, r >= g - 1 && r <= g + 1});
        if (oc) begin
            while (LATCHED_OFF !== 1'b1 && n < 4000) begin
                @(negedge ref_clk);
                n++;
            end
            chk("latchoff", 20'h1, {19'h0, n + 2 >= 4 * lim && n <= 4 * lim + 3});
        end else begin
            // output leaving its window drops the registered good flag one cycle later, for one cycle
            @(posedge ref_clk);
            win <= 1'b0;
            @(posedge ref_clk);
            win <= 1'b1;
            @(negedge ref_clk);
            chk("good_win", 20'h0, {19'h0, OUTPUT_GOOD_FLAG});
            @(negedge ref_clk);
            chk("good_back", 20'h1, {19'h0, OUTPUT_GOOD_FLAG});
        end
        @(posedge ref_clk);
        en <= 1'b0;
        ocur <= 1'b0;
        @(posedge ref_clk);
        en <= oc;
        repeat (3) @(negedge ref_clk);
        chk("latched", 20'h0, {19'h0, LATCHED_OFF});
        chk("off_drv", 20'h0, {16'h0, PHASE_DRIVE_O});
        chk("off_good", 20'h0, {19'h0, OUTPUT_GOOD_FLAG});
        @(posedge ref_clk);
        en <= 1'b0;
    endtask : start_up

    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'hD4, v);
        chk("dly_rst", 20'h3, {12'h0, v});
        rd(8'hD5, v);
        chk("slew_rst", 20'h2, {12'h0, v});
        chk("oe_rst", 20'h1, {16'h0, PHASE_DRIVE_OE});
        for (int i = 0; i < 10; i++) begin
            wr(tab[i][0], tab[i][1]);
            rd(tab[i][0], v);
            chk("rdata", {12'h0, tab[i][2]}, {12'h0, v});
        end
        start_up(3'h0, 3'h7, 3'h0, 8'hB0, 1'b0, 1'b0);
        start_up(3'h7, 3'h0, 3'h6, 8'h90, 1'b1, 1'b0);
        start_up(3'h3, 3'h2, 3'h7, 8'h90, 1'b0, 1'b1);
        start_up(3'h2, 3'h5, 3'h4, 8'h90, 1'b0, 1'b1);
        complete_run();
    end
endmodule : mpss_sequencer_tb_top
`default_nettype wire
